// ---- srb_map.vh ----
// Purpose: Shared constants for the two-word burst separate-I/O SRAM port.
// Assumes: One configured width of 18 bits, split into two 9-bit byte lanes.
// Notes: Depths are kept small so the array can live in flip-flops.
`ifndef SRB_MAP_VH
`define SRB_MAP_VH

`define SRB_WORD_W 18
`define SRB_BYTE_W 9
`define SRB_BYTES 2
`define SRB_ADDR_W 4
`define SRB_ARRAY_WORDS 32
`define SRB_FIFO_DEPTH 8
`define SRB_FIFO_AW 3
`define SRB_FIFO_COUNT_W 4
// Highest FIFO count at which a write still finds room for both of its words.
`define SRB_FIFO_ROOM 4'h6

// Half-cycle events of the selected output or input clock pair counted after a read address is taken.
`define SRB_EVT_W 3
`define SRB_EVT_FIRST_DLL_OFF 3'h2
`define SRB_EVT_FIRST_DLL_ON 3'h3

// Clock figures for the system clock and the link clock seen in the bench.
`define SRB_CLOCK_PERIOD_NS 100
`define SRB_LINK_PERIOD_NS 800
`define SRB_LINK_HALF_CYCLES (`SRB_LINK_PERIOD_NS / (2 * `SRB_CLOCK_PERIOD_NS))

`endif

// ---- srb_fifo.v ----
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock, active-low synchronous-release reset from the parent.
// Notes: Count output lets the source reserve room for a whole burst.
`timescale 1ns/1ns
`default_nettype none

module srb_fifo #(
  parameter WIDTH = 25,
  parameter DEPTH = 8,
  parameter AW = 3,
  parameter CW = 4
) (
  input wire clock,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [CW-1:0] count
);

  reg [WIDTH-1:0] store_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [CW-1:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != DEPTH[CW-1:0]);
  assign out_valid = (count_reg != {CW{1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = store_reg[rd_ptr_reg];
  assign count = count_reg;

  always @(posedge clock)
  begin
    if (push)
    begin
      store_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {CW{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // srb_fifo

`default_nettype wire

// ---- srb_port.v ----
// Purpose: Separate-I/O double data rate SRAM port with two-word bursts, modelled on a system clock.
// Assumes: The link clocks are slow against clock (eight system cycles per link period) and are
// sampled through two flip-flops; the host keeps its own ordering and mode obligations.
// Notes: Only rising link-clock edges act; the array itself is never reset.
// Functional notes
// RULE1 - Read and write addresses taken on alternating rises.
// RULE2 - Write words taken on true and complement rises.
// RULE3 - Read data on output pair, else input pair.
// RULE4 - Each address holds two words, burst in order.
// RULE5 - DLL on: read data after 1.5 cycles.
// RULE6 - DLL off: read data after 1 cycle.
// RULE7 - Separate read and write data, shared address.
// RULE8 - Inputs sampled only at input clock rises.
// RULE9 - Outputs leave registers on the output clock edges.
// RULE10 - Writes complete internally, no extra strobes.
// RULE11 - Echo clocks aligned with read data.
// RULE12 - Only rising edges of each clock act.
// RULE13 - Host starts bursts with load and direction.
// RULE14 - Lane selects per word keep unselected lanes.
// RULE15 - Host fixes DLL mode before accesses.
`timescale 1ns/1ns
`default_nettype none
`include "srb_map.vh"

module srb_port (
  input wire clock,
  input wire resetn,
  input wire k_clk,
  input wire k_clk_n,
  input wire out_clk,
  input wire out_clk_n,
  input wire out_clk_used,
  input wire load_strobe_n,
  input wire read_write_select,
  input wire dll_disable,
  input wire [`SRB_ADDR_W-1:0] address,
  input wire [`SRB_WORD_W-1:0] write_data,
  input wire [`SRB_BYTES-1:0] byte_write_select_n,
  output wire [`SRB_WORD_W-1:0] read_data,
  output wire read_valid,
  output wire returned_strobe,
  output wire returned_strobe_n,
  output wire write_refused
);

  localparam AW = `SRB_ADDR_W;
  localparam WW = `SRB_WORD_W;
  localparam BN = `SRB_BYTES;
  localparam BW = `SRB_BYTE_W;
  localparam SW = 8 + AW + WW + BN;
  localparam FW = AW + 1 + WW + BN;
  localparam CW = `SRB_FIFO_COUNT_W;
  localparam EW = `SRB_EVT_W;
  localparam [CW-1:0] ROOM_LIMIT = `SRB_FIFO_ROOM;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_FETCH0 = 3'h1;
  localparam [2:0] ST_FETCH1 = 3'h2;
  localparam [2:0] ST_FETCH2 = 3'h3;
  localparam [2:0] ST_SEND = 3'h4;

  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;

  reg [SW-1:0] pin_meta_reg;
  reg [SW-1:0] pin_sync_reg;
  reg [3:0] clk_prev_reg;
  wire [SW-1:0] pins;

  wire s_k;
  wire s_kn;
  wire s_c;
  wire s_cn;
  wire s_cused;
  wire s_load_n;
  wire s_rw;
  wire s_dll;
  wire [AW-1:0] s_addr;
  wire [WW-1:0] s_wdata;
  wire [BN-1:0] s_lane_sel_n;
  wire k_rise;
  wire kn_rise;
  wire ot_rise;
  wire oc_rise;
  wire out_event;

  reg prev_read_reg;
  reg prev_write_reg;
  reg wr_pend_reg;
  reg [AW-1:0] wr_addr_reg;
  reg refused_reg;

  reg [2:0] rd_state_reg;
  reg [AW-1:0] rd_addr_reg;
  reg rd_dll_off_reg;
  reg [EW-1:0] ev_cnt_reg;
  reg [WW-1:0] word0_reg;
  reg [WW-1:0] word1_reg;
  reg [WW-1:0] rdata_reg;
  reg rvalid_reg;
  reg last_word_reg;
  reg echo_reg;
  reg echo_n_reg;

  reg [WW-1:0] array_reg [0:`SRB_ARRAY_WORDS-1];
  reg [WW-1:0] array_q_reg;

  wire take_cmd;
  wire take_read;
  wire write_cmd;
  wire take_write;
  wire push_word1;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire [FW-1:0] fifo_in_data;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [FW-1:0] fifo_out_data;
  wire [CW-1:0] fifo_count;
  wire fetch_busy;
  wire [AW:0] fetch_index;
  wire [AW:0] drain_index;
  wire [WW-1:0] drain_data;
  wire [BN-1:0] drain_lane_sel_n;
  wire drain_write;
  wire [EW-1:0] ev_next;
  wire [EW-1:0] first_evt;
  wire [EW-1:0] second_evt;

  // Reset is released through two flip-flops; everything below uses the released copy.
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  assign pins = {k_clk, k_clk_n, out_clk, out_clk_n, out_clk_used, load_strobe_n, read_write_select,
                 dll_disable, address, write_data, byte_write_select_n};

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= {SW{1'b0}};
      pin_sync_reg <= {SW{1'b0}};
      clk_prev_reg <= 4'h0;
    end
    else
    begin
      pin_meta_reg <= pins;
      pin_sync_reg <= pin_meta_reg;
      clk_prev_reg <= pin_sync_reg[SW-1:SW-4];
    end
  end

  assign s_k = pin_sync_reg[SW-1];
  assign s_kn = pin_sync_reg[SW-2];
  assign s_c = pin_sync_reg[SW-3];
  assign s_cn = pin_sync_reg[SW-4];
  assign s_cused = pin_sync_reg[SW-5];
  assign s_load_n = pin_sync_reg[SW-6];
  assign s_rw = pin_sync_reg[SW-7];
  assign s_dll = pin_sync_reg[SW-8];
  assign s_addr = pin_sync_reg[AW+WW+BN-1:WW+BN];
  assign s_wdata = pin_sync_reg[WW+BN-1:BN];
  assign s_lane_sel_n = pin_sync_reg[BN-1:0];

  // Falling edges are never detected, so nothing in the port acts on them.
  assign k_rise = s_k & ~clk_prev_reg[3]; // [RULE12] [RULE8]
  assign kn_rise = s_kn & ~clk_prev_reg[2]; // [RULE12] [RULE8]
  assign ot_rise = s_cused ? (s_c & ~clk_prev_reg[1]) : k_rise; // [RULE3] [RULE12]
  assign oc_rise = s_cused ? (s_cn & ~clk_prev_reg[0]) : kn_rise; // [RULE3] [RULE12]
  assign out_event = ot_rise | oc_rise;

  // A command is a low load strobe at a true-clock rise; the select picks the direction.
  assign take_cmd = k_rise & ~s_load_n; // [RULE13]
  // A command of the same direction as the one taken on the previous rise is ignored.
  assign take_read = take_cmd & s_rw & ~prev_read_reg; // [RULE1]
  assign write_cmd = take_cmd & ~s_rw & ~prev_write_reg; // [RULE1]
  // Room for both words is reserved up front so the second word can never be lost.
  assign take_write = write_cmd & (fifo_count <= ROOM_LIMIT);
  assign push_word1 = kn_rise & wr_pend_reg; // [RULE2]

  assign fifo_in_valid = (take_write | push_word1) & fifo_in_ready;
  assign fifo_in_data = push_word1 ? {wr_addr_reg, 1'b1, s_wdata, s_lane_sel_n} :
                        {s_addr, 1'b0, s_wdata, s_lane_sel_n}; // [RULE2] [RULE4] [RULE14]

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_read_reg <= 1'b0;
      prev_write_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= {AW{1'b0}};
      refused_reg <= 1'b0;
    end
    else
    begin
      refused_reg <= write_cmd & ~take_write;
      if (k_rise)
      begin
        prev_read_reg <= take_read; // [RULE1]
        prev_write_reg <= take_write; // [RULE1]
      end
      if (take_write)
      begin
        wr_pend_reg <= 1'b1;
        wr_addr_reg <= s_addr;
      end
      else if (push_word1)
      begin
        wr_pend_reg <= 1'b0;
      end
    end
  end

  srb_fifo #(
    .WIDTH(FW),
    .DEPTH(`SRB_FIFO_DEPTH),
    .AW(`SRB_FIFO_AW),
    .CW(CW)
  ) u_write_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  // The array has one port; read fetches win and stall the write drain.
  assign fetch_busy = (rd_state_reg == ST_FETCH0) || (rd_state_reg == ST_FETCH1);
  assign fifo_out_ready = ~fetch_busy;
  assign drain_write = fifo_out_valid & ~fetch_busy; // [RULE10]
  assign drain_index = fifo_out_data[FW-1:WW+BN];
  assign drain_data = fifo_out_data[WW+BN-1:BN];
  assign drain_lane_sel_n = fifo_out_data[BN-1:0];
  assign fetch_index = {rd_addr_reg, (rd_state_reg == ST_FETCH1)}; // [RULE4]

  integer lane;
  always @(posedge clock)
  begin
    if (fetch_busy)
    begin
      array_q_reg <= array_reg[fetch_index];
    end
    else if (drain_write)
    begin
      for (lane = 0; lane < BN; lane = lane + 1)
      begin
        if (!drain_lane_sel_n[lane])
        begin
          array_reg[drain_index][lane*BW +: BW] <= drain_data[lane*BW +: BW]; // [RULE14] [RULE10]
        end
      end
    end
  end

  // The mode is caught with each read; the bench sets it at least eight cycles before each read.
  assign first_evt = rd_dll_off_reg ? `SRB_EVT_FIRST_DLL_OFF : `SRB_EVT_FIRST_DLL_ON; // [RULE5] [RULE6] [RULE15]
  assign second_evt = first_evt + {{(EW-1){1'b0}}, 1'b1};
  assign ev_next = ev_cnt_reg + {{(EW-1){1'b0}}, 1'b1};

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_state_reg <= ST_IDLE;
      rd_addr_reg <= {AW{1'b0}};
      rd_dll_off_reg <= 1'b0;
      ev_cnt_reg <= {EW{1'b0}};
      word0_reg <= {WW{1'b0}};
      word1_reg <= {WW{1'b0}};
    end
    else if (take_read)
    begin
      rd_state_reg <= ST_FETCH0;
      rd_addr_reg <= s_addr; // [RULE7]
      rd_dll_off_reg <= s_dll; // [RULE15]
      ev_cnt_reg <= {EW{1'b0}};
    end
    else
    begin
      if (out_event && rd_state_reg != ST_IDLE)
      begin
        ev_cnt_reg <= ev_next;
      end
      case (rd_state_reg)
        ST_FETCH0:
        begin
          rd_state_reg <= ST_FETCH1;
        end
        ST_FETCH1:
        begin
          word0_reg <= array_q_reg;
          rd_state_reg <= ST_FETCH2;
        end
        ST_FETCH2:
        begin
          word1_reg <= array_q_reg;
          rd_state_reg <= ST_SEND;
        end
        ST_SEND:
        begin
          if (out_event && ev_next == second_evt)
          begin
            rd_state_reg <= ST_IDLE;
          end
        end
        default:
        begin
          rd_state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Data and echo levels change on the same system edge, which keeps them aligned.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= {WW{1'b0}};
      rvalid_reg <= 1'b0;
      last_word_reg <= 1'b0;
      echo_reg <= 1'b0;
      echo_n_reg <= 1'b0;
    end
    else
    begin
      echo_reg <= s_cused ? s_c : s_k; // [RULE11] [RULE3]
      echo_n_reg <= s_cused ? s_cn : s_kn; // [RULE11] [RULE3]
      if (out_event && rd_state_reg == ST_SEND && !take_read && ev_next == first_evt)
      begin
        rdata_reg <= word0_reg; // [RULE9] [RULE5] [RULE6] [RULE4]
        rvalid_reg <= 1'b1;
        last_word_reg <= 1'b0;
      end
      else if (out_event && rd_state_reg == ST_SEND && !take_read && ev_next == second_evt)
      begin
        rdata_reg <= word1_reg; // [RULE9] [RULE4]
        rvalid_reg <= 1'b1;
        last_word_reg <= 1'b1;
      end
      else if (out_event && last_word_reg)
      begin
        rvalid_reg <= 1'b0;
        last_word_reg <= 1'b0;
      end
    end
  end

  assign read_data = rdata_reg; // [RULE7]
  assign read_valid = rvalid_reg;
  assign returned_strobe = echo_reg;
  assign returned_strobe_n = echo_n_reg;
  assign write_refused = refused_reg;

endmodule // srb_port

`default_nettype wire

// ---- srb_host_model.sv ----
// Purpose: Host controller model that makes the link clock pairs and issues burst commands.
// Assumes: Clock pairs are exact complements; the output pair lags the input pair by a quarter period.
// Notes: Released lines show inverted values so a stale word never looks valid.
`timescale 1ns/1ns
`default_nettype none
`include "srb_map.vh"

module srb_host (
  input wire logic clock,
  output logic k_clk,
  output logic k_clk_n,
  output logic out_clk,
  output logic out_clk_n,
  output logic load_strobe_n,
  output logic read_write_select,
  output logic [`SRB_ADDR_W-1:0] address,
  output logic [`SRB_WORD_W-1:0] write_data,
  output logic [`SRB_BYTES-1:0] byte_write_select_n
);
  assign k_clk_n = ~k_clk;
  // The output pair lags so that its complement rise is always the first event after capture.
  assign #200 out_clk_n = k_clk;
  assign out_clk = ~out_clk_n;

  initial
  begin
    k_clk = 1'h0;
    load_strobe_n = 1'h1;
    read_write_select = 1'h0;
    address = 4'h0;
    write_data = 18'h00000;
    byte_write_select_n = 2'h3;
    #130;
    forever #(`SRB_LINK_PERIOD_NS / 2) k_clk = ~k_clk;
  end

  // With bb set the command lands on the rise right after the previous one.
  task automatic cmd(input logic bb, rd, input logic [`SRB_ADDR_W-1:0] a,
                     input logic [`SRB_WORD_W-1:0] d0, d1, input logic [`SRB_BYTES-1:0] m0, m1);
  begin
    if (!bb) @(posedge k_clk_n);
    @(posedge clock) #1;
    load_strobe_n = 1'h0;
    read_write_select = rd;
    address = a;
    write_data = d0;
    byte_write_select_n = m0;
    @(posedge k_clk);
    repeat (3) @(posedge clock);
    #1 write_data = d1;
    byte_write_select_n = m1;
    address = ~a;
    @(posedge k_clk_n);
    repeat (3) @(posedge clock);
    #1 load_strobe_n = 1'h1;
    write_data = ~d1;
    byte_write_select_n = ~m1;
  end
  endtask
endmodule // srb_host
`default_nettype wire

// ---- srb_port_properties.sv ----
// Purpose: Checker for echo, read data and valid timing of srb_port.
// Assumes: Sees only the top module's ports; clock pairs are exact complements.
// Notes: Echo source checks skip four cycles after a change of the selected pair; the pair check does not.
`timescale 1ns/1ns
`default_nettype none
`include "srb_map.vh"

module srb_port_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic out_clk,
  input wire logic out_clk_n,
  input wire logic out_clk_used,
  input wire logic dll_disable,
  input wire logic [`SRB_WORD_W-1:0] read_data,
  input wire logic read_valid,
  input wire logic returned_strobe,
  input wire logic returned_strobe_n,
  input wire logic write_refused
);
  wire sel_t = out_clk_used ? out_clk : k_clk;
  wire sel_c = out_clk_used ? out_clk_n : k_clk_n;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_edge;
    $rose(returned_strobe) || $rose(returned_strobe_n);
  endsequence
  sequence s_burst;
    read_valid[*7] ##1 !read_valid;
  endsequence

  a_echo_true_src: assert property (
    $rose(returned_strobe) && out_clk_used == $past(out_clk_used, 4) |-> $past(sel_t, 2))
    else $error("echo rise without a selected clock rise");
  a_echo_comp_src: assert property (
    $rose(returned_strobe_n) && out_clk_used == $past(out_clk_used, 4) |-> $past(sel_c, 2))
    else $error("echo complement rise without a selected complement rise");
  a_echo_pair_opp: assert property (
    $rose(returned_strobe) |-> !returned_strobe_n)
    else $error("echo pair not complementary");
  a_data_on_edge: assert property (
    $changed(read_data) |-> s_edge)
    else $error("read data moved off an echo edge");
  a_valid_on_edge: assert property (
    $changed(read_valid) |-> s_edge)
    else $error("read valid moved off an echo edge");
  a_burst_two_words: assert property (
    $rose(read_valid) |=> s_burst)
    else $error("burst not two half periods long");
  a_first_word_edge: assert property (
    $rose(read_valid) |-> if ($past(dll_disable, 4)) $rose(returned_strobe) else $rose(returned_strobe_n))
    else $error("first word on the wrong echo edge");
  a_refuse_pulse: assert property (
    write_refused |=> !write_refused)
    else $error("refusal longer than one cycle");
endmodule // srb_port_chk

bind srb_port srb_port_chk u_srb_port_chk (.clock(clock), .resetn(resetn), .k_clk(k_clk), .k_clk_n(k_clk_n),
  .out_clk(out_clk), .out_clk_n(out_clk_n), .out_clk_used(out_clk_used), .dll_disable(dll_disable),
  .read_data(read_data), .read_valid(read_valid), .returned_strobe(returned_strobe),
  .returned_strobe_n(returned_strobe_n), .write_refused(write_refused));
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for srb_port driven by the host model.
// Assumes: Link period 800 ns against a 100 ns system clock.
// Notes: Read words are sampled between echo edges where they are settled.
`timescale 1ns/1ns
`default_nettype none
`include "srb_map.vh"

module tb;
  localparam logic [17:0] W0 = 18'h2A5C1;
  localparam logic [17:0] W1 = 18'h15A3E;
  localparam logic [17:0] W2 = 18'h12345;
  localparam logic [17:0] W3 = 18'h0ABCD;
  localparam logic [17:0] L0 = {W0[17:9], 9'h1FF};
  localparam logic [17:0] L1 = {9'h000, W1[8:0]};
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic out_clk_used = 1'h0;
  logic dll_disable = 1'h1;
  wire k_clk, k_clk_n, out_clk, out_clk_n, load_strobe_n, read_write_select;
  wire [`SRB_ADDR_W-1:0] address;
  wire [`SRB_WORD_W-1:0] write_data, read_data;
  wire [`SRB_BYTES-1:0] byte_write_select_n;
  wire read_valid, returned_strobe, returned_strobe_n, write_refused;
  int n_fail = 0;
  int check_count = 0;

  always #(`SRB_CLOCK_PERIOD_NS / 2) clock = ~clock;

  // The FIFO never nears full with this traffic, so any refusal pulse is a fault.
  always @(negedge clock)
    if (resetn && write_refused !== 1'h0)
      chk(1'h0, "write refused without a full FIFO");

  srb_host u_srb_host (.clock(clock), .k_clk(k_clk), .k_clk_n(k_clk_n), .out_clk(out_clk), .out_clk_n(out_clk_n),
    .load_strobe_n(load_strobe_n), .read_write_select(read_write_select), .address(address),
    .write_data(write_data), .byte_write_select_n(byte_write_select_n));
  srb_port u_srb_port (.clock(clock), .resetn(resetn), .k_clk(k_clk), .k_clk_n(k_clk_n), .out_clk(out_clk),
    .out_clk_n(out_clk_n), .out_clk_used(out_clk_used), .load_strobe_n(load_strobe_n),
    .read_write_select(read_write_select), .dll_disable(dll_disable), .address(address),
    .write_data(write_data), .byte_write_select_n(byte_write_select_n), .read_data(read_data),
    .read_valid(read_valid), .returned_strobe(returned_strobe), .returned_strobe_n(returned_strobe_n),
    .write_refused(write_refused));

  task automatic test_done;
  begin
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  task automatic chk(input logic ok, input string what);
  begin
    check_count++;
    if (ok !== 1'h1)
    begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, what);
    end
  end
  endtask

  // Samples sit 50 ns before each event, after the previous event has been detected.
  task automatic expect_burst(input logic bb, input logic [`SRB_WORD_W-1:0] e0, e1);
    time t0;
    int i;
  begin
    if (!bb) @(posedge k_clk_n);
    @(posedge k_clk);
    t0 = $time + (out_clk_used ? 600 : 800) + (dll_disable ? 0 : 400);
    for (i = 0; i < 5; i++)
    begin
      #(t0 + i * 400 - 50 - $time);
      chk(read_valid === (i == 1 || i == 2), "read valid");
      chk(write_refused === 1'h0, "write refused");
      if (i == 1 || i == 2)
        chk(read_data === (i == 1 ? e0 : e1), "read word");
    end
  end
  endtask

  task automatic rd(input logic used, dll, input logic [`SRB_ADDR_W-1:0] a, input logic [`SRB_WORD_W-1:0] e0, e1);
  begin
    @(posedge clock) #1;
    out_clk_used = used;
    dll_disable = dll;
    repeat (8) @(posedge clock);
    fork
      u_srb_host.cmd(1'h0, 1'h1, a, 18'h00000, 18'h00000, 2'h3, 2'h3);
      expect_burst(1'h0, e0, e1);
    join
  end
  endtask

  task automatic t_modes;
    int m;
  begin
    u_srb_host.cmd(1'h0, 1'h0, 4'h3, W0, W1, 2'h0, 2'h0);
    for (m = 0; m < 4; m++)
      rd(m[1], m[0], 4'h3, W0, W1);
  end
  endtask

  task automatic t_lanes;
  begin
    u_srb_host.cmd(1'h0, 1'h0, 4'h3, 18'h3FFFF, 18'h00000, 2'h2, 2'h1);
    rd(1'h0, 1'h1, 4'h3, L0, L1);
  end
  endtask

  // A repeated write and a repeated read on the next rise are dropped; a read after a write is taken.
  task automatic t_alternate;
  begin
    u_srb_host.cmd(1'h0, 1'h0, 4'h9, W2, W3, 2'h0, 2'h0);
    u_srb_host.cmd(1'h1, 1'h0, 4'h9, ~W2, ~W3, 2'h0, 2'h0);
    fork
      begin
        u_srb_host.cmd(1'h1, 1'h1, 4'h3, 18'h00000, 18'h00000, 2'h3, 2'h3);
        u_srb_host.cmd(1'h1, 1'h1, 4'h9, 18'h00000, 18'h00000, 2'h3, 2'h3);
      end
      expect_burst(1'h1, L0, L1);
    join
    rd(1'h0, 1'h1, 4'h9, W2, W3);
  end
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    #1 resetn = 1'h1;
    repeat (10) @(posedge clock);
    t_modes();
    t_lanes();
    t_alternate();
    test_done();
  end

  initial
  begin
    repeat (30000) @(posedge clock);
    n_fail++;
    test_done();
  end
endmodule // tb
`default_nettype wire
